//--- design/profile_access_monitor.sv
// Profile timer, pass counter and exceptional event detector of a target monitor.
// Assumes the target access, stack and task signals are synchronous to I_MCLK.
//
// Behaviour
// - Timer resolution is chosen from 10, 20, 40, 80, 160 ns or 1.6 us.
// - Changing the measurement interval clears all accumulated profile results.
// - Execution time is measured with a 40-bit counter.
// - Passes are counted by a 16-bit counter reaching at most 65,535.
// - Profile overflow event when time or pass counter exceeds its maximum.
// - Access-protection event when an access breaks the addressed word attribute.
// - Written words of a TRACK_WORDS window are tracked; reading an unwritten word there raises an event.
// - Stack violation event when stack pointer leaves configured stack limits.
// - Performance overflow event when the section time counter overflows.
// - Trace overflow event when trace storage fills beyond capacity.
// - Task stack event when a task writes another task's stack region.
// - Dispatch event whenever the running task changes.
// - Attributes per word: read-write, read-only, write-only, disabled, disabled-except-OS.
// - Disabled-except-OS words flag every access not coming from OS code.
// - After reset all addresses are read-write, so nothing is flagged.
// - Sixteen comparison blocks hold protected regions; no more regions exist.
// - Flag writes to read-only, reads of write-only, any access to disabled.
// - Selected events drive breakpoint and trace point trigger outputs.
`timescale 1ns/1ps

module profile_access_monitor #(
	parameter int NUM_BLOCKS = 16,
	parameter int TRACK_WORDS = 256,
	parameter int NUM_TASKS = 4
) (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	// Register port.
	input wire logic [pam_pkg::REG_AW-1:0] I_ADDR,
	input wire logic [pam_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [pam_pkg::DATA_W-1:0] O_RDATA,
	// Observed target.
	input wire pam_pkg::access_t I_ACC,
	input wire logic [pam_pkg::ADDR_W-1:0] I_SP,
	input wire logic I_SP_VALID,
	input wire logic [pam_pkg::TASK_W-1:0] I_TASK_ID,
	input wire logic I_TASK_VALID,
	input wire logic I_PROF_ENTER,
	input wire logic I_PROF_ACTIVE,
	input wire logic I_SECT_ACTIVE,
	input wire logic I_TRACE_WR,
	input wire logic I_TRACE_FULL,
	// Events and triggers.
	output logic O_IRQ,
	output logic [pam_pkg::EV_N-1:0] O_EVENT,
	output logic O_BRK_TRIG,
	output logic O_TRC_TRIG
);

	localparam int TW = pam_pkg::TIME_W;
	localparam int AW = pam_pkg::ADDR_W;
	localparam int MW = $clog2(TRACK_WORDS);
	localparam logic [TW-1:0] TIME_MAX = {TW{1'b1}};
	localparam logic [pam_pkg::PASS_W-1:0] PASS_MAX = {pam_pkg::PASS_W{1'b1}};

	logic [7:0] ctrl_reg;
	pam_pkg::interval_t interval_reg;
	logic [pam_pkg::EV_N-1:0] status_reg;
	logic [pam_pkg::EV_N-1:0] mask_reg;
	logic [pam_pkg::EV_N-1:0] brk_sel_reg;
	logic [pam_pkg::EV_N-1:0] trc_sel_reg;
	logic [AW-1:0] stack_lo_reg;
	logic [AW-1:0] stack_hi_reg;
	logic [AW-1:0] track_base_reg;
	logic [AW-1:0] blk_start_reg [NUM_BLOCKS];
	logic [AW-1:0] blk_end_reg [NUM_BLOCKS];
	logic [3:0] blk_attr_reg [NUM_BLOCKS];
	logic [AW-1:0] tsk_lo_reg [NUM_TASKS];
	logic [AW-1:0] tsk_hi_reg [NUM_TASKS];
	logic [TW-1:0] time_reg [2];
	logic [pam_pkg::PASS_W-1:0] pass_reg;
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic [2:0] tick_n;
	logic [TRACK_WORDS-1:0] written_reg;
	logic [pam_pkg::TASK_W-1:0] task_reg;
	logic [pam_pkg::EV_N-1:0] ev;
	logic [2:0] tmr_ovf;
	logic clr_prof;
	logic blk_hit_any;
	logic [3:0] blk_attr_sel;
	logic [NUM_BLOCKS-1:0] blk_hit;
	logic [NUM_TASKS-1:0] tsk_hit;
	logic [AW-1:0] map_off;
	logic [pam_pkg::DATA_W-1:0] rdata_next;
	logic [7:0] sum;

	// Changing the interval would mix ticks of two resolutions, so results restart.
	assign clr_prof = (I_WR && I_ADDR == pam_pkg::REG_INTERVAL && I_WDATA[2:0] != interval_reg)
		|| (I_WR && I_ADDR == pam_pkg::REG_CTRL && I_WDATA[pam_pkg::CTRL_CLR_PROF]);

	// The clock is slower than the finest resolutions, so each cycle may add several ticks.
	always_comb begin
		sum = acc_reg + 8'(pam_pkg::CLK_UNITS);
		tick_n = 3'h0;
		acc_next = 8'h00;
		unique case (interval_reg)
			pam_pkg::INT_10NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_10NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_10NS_NS / pam_pkg::RES_UNIT_NS));
			end
			pam_pkg::INT_20NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_20NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_20NS_NS / pam_pkg::RES_UNIT_NS));
			end
			pam_pkg::INT_40NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_40NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_40NS_NS / pam_pkg::RES_UNIT_NS));
			end
			pam_pkg::INT_80NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_80NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_80NS_NS / pam_pkg::RES_UNIT_NS));
			end
			pam_pkg::INT_160NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_160NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_160NS_NS / pam_pkg::RES_UNIT_NS));
			end
			pam_pkg::INT_1600NS: begin
				tick_n = 3'(sum / 8'(pam_pkg::RES_1600NS_NS / pam_pkg::RES_UNIT_NS));
				acc_next = 8'(sum % 8'(pam_pkg::RES_1600NS_NS / pam_pkg::RES_UNIT_NS));
			end
			default: begin
				tick_n = 3'h0;
				acc_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			acc_reg <= 8'h00;
		end else if (clr_prof) begin
			acc_reg <= 8'h00;
		end else begin
			acc_reg <= acc_next;
		end
	end

	// Timer 0 measures the profiled function or task, timer 1 the program section.
	genvar gt;
	generate
		for (gt = 0; gt < 2; gt++) begin : g_timer
			logic run;
			logic [TW:0] nxt;
			assign run = (gt == 0) ? I_PROF_ACTIVE : I_SECT_ACTIVE;
			assign nxt = {1'b0, time_reg[gt]} + (TW+1)'(tick_n);
			assign tmr_ovf[gt] = run && nxt[TW];
			always_ff @(posedge I_MCLK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					time_reg[gt] <= '0;
				end else if (clr_prof) begin
					time_reg[gt] <= '0;
				end else if (run) begin
					time_reg[gt] <= nxt[TW] ? TIME_MAX : nxt[TW-1:0];
				end
			end
		end
	endgenerate

	assign tmr_ovf[2] = I_PROF_ENTER && pass_reg == PASS_MAX;

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pass_reg <= '0;
		end else if (clr_prof) begin
			pass_reg <= '0;
		end else if (I_PROF_ENTER && pass_reg != PASS_MAX) begin
			pass_reg <= pass_reg + 16'h0001;
		end
	end

	// Block compare; the lowest hit block decides, no hit leaves read-write.
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BLOCKS; gb++) begin : g_blk
			assign blk_hit[gb] = blk_attr_reg[gb][pam_pkg::BLK_EN_BIT]
				&& I_ACC.addr >= blk_start_reg[gb] && I_ACC.addr <= blk_end_reg[gb];
		end
		for (gb = 0; gb < NUM_TASKS; gb++) begin : g_tsk
			assign tsk_hit[gb] = I_ACC.valid && I_ACC.write && I_ACC.task_id != gb
				&& I_ACC.addr >= tsk_lo_reg[gb] && I_ACC.addr <= tsk_hi_reg[gb];
		end
	endgenerate

	always_comb begin
		blk_attr_sel = {1'b0, pam_pkg::ATTR_RW};
		blk_hit_any = 1'b0;
		for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
			if (blk_hit[i]) begin
				blk_attr_sel = blk_attr_reg[i];
				blk_hit_any = 1'b1;
			end
		end
	end

	assign map_off = I_ACC.addr - track_base_reg;

	always_comb begin
		ev = '0;
		if (I_ACC.valid && blk_hit_any) begin
			unique case (blk_attr_sel[2:0])
				pam_pkg::ATTR_RW: ev[pam_pkg::EV_PROT] = 1'b0;
				pam_pkg::ATTR_RO: ev[pam_pkg::EV_PROT] = I_ACC.write;
				pam_pkg::ATTR_WO: ev[pam_pkg::EV_PROT] = !I_ACC.write;
				pam_pkg::ATTR_DIS: ev[pam_pkg::EV_PROT] = 1'b1;
				pam_pkg::ATTR_DIS_OS: ev[pam_pkg::EV_PROT] = !I_ACC.os;
				default: ev[pam_pkg::EV_PROT] = 1'b0;
			endcase
		end
		ev[pam_pkg::EV_UNINIT] = ctrl_reg[pam_pkg::CTRL_UNINIT_EN] && I_ACC.valid
			&& !I_ACC.write && I_ACC.addr >= track_base_reg
			&& map_off < AW'(TRACK_WORDS) && !written_reg[map_off[MW-1:0]];
		ev[pam_pkg::EV_STACK] = ctrl_reg[pam_pkg::CTRL_STACK_EN] && I_SP_VALID
			&& (I_SP < stack_lo_reg || I_SP > stack_hi_reg);
		ev[pam_pkg::EV_PERF_OVF] = tmr_ovf[1];
		ev[pam_pkg::EV_PROF_OVF] = tmr_ovf[0] || tmr_ovf[2];
		ev[pam_pkg::EV_TRACE_OVF] = I_TRACE_WR && I_TRACE_FULL;
		ev[pam_pkg::EV_TASK_STACK] = |tsk_hit;
		ev[pam_pkg::EV_DISPATCH] = I_TASK_VALID && I_TASK_ID != task_reg;
	end

	// Written-word map covers a window only; a full-space map would need external memory.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			written_reg <= '0;
		end else if (I_WR && I_ADDR == pam_pkg::REG_CTRL && I_WDATA[pam_pkg::CTRL_CLR_MAP]) begin
			written_reg <= '0;
		end else if (I_ACC.valid && I_ACC.write && I_ACC.addr >= track_base_reg
				&& map_off < AW'(TRACK_WORDS)) begin
			written_reg[map_off[MW-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			task_reg <= '0;
		end else if (I_TASK_VALID) begin
			task_reg <= I_TASK_ID;
		end
	end

	// Status is sticky; an event in the clearing cycle survives the clear.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			status_reg <= '0;
		end else if (I_WR && I_ADDR == pam_pkg::REG_STATUS) begin
			status_reg <= (status_reg & ~I_WDATA[pam_pkg::EV_N-1:0]) | ev;
		end else begin
			status_reg <= status_reg | ev;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_EVENT <= '0;
			O_BRK_TRIG <= 1'b0;
			O_TRC_TRIG <= 1'b0;
		end else begin
			O_EVENT <= ev;
			O_BRK_TRIG <= |(ev & brk_sel_reg);
			O_TRC_TRIG <= |(ev & trc_sel_reg);
		end
	end

	assign O_IRQ = |(status_reg & mask_reg);

	// Configuration registers; clear bits of the control register self-clear.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_reg <= '0;
			interval_reg <= pam_pkg::interval_t'(pam_pkg::INTERVAL_RST);
			mask_reg <= '0;
			brk_sel_reg <= '0;
			trc_sel_reg <= '0;
			stack_lo_reg <= '0;
			stack_hi_reg <= '1;
			track_base_reg <= '0;
		end else begin
			ctrl_reg[pam_pkg::CTRL_CLR_PROF] <= 1'b0;
			ctrl_reg[pam_pkg::CTRL_CLR_MAP] <= 1'b0;
			if (I_WR) begin
				unique case (I_ADDR)
					pam_pkg::REG_CTRL: begin
						ctrl_reg[pam_pkg::CTRL_STACK_EN] <= I_WDATA[pam_pkg::CTRL_STACK_EN];
						ctrl_reg[pam_pkg::CTRL_UNINIT_EN] <= I_WDATA[pam_pkg::CTRL_UNINIT_EN];
					end
					pam_pkg::REG_INTERVAL: begin
						if (I_WDATA[2:0] <= pam_pkg::INT_1600NS) begin
							interval_reg <= pam_pkg::interval_t'(I_WDATA[2:0]);
						end
					end
					pam_pkg::REG_MASK: mask_reg <= I_WDATA[pam_pkg::EV_N-1:0];
					pam_pkg::REG_BRK_SEL: brk_sel_reg <= I_WDATA[pam_pkg::EV_N-1:0];
					pam_pkg::REG_TRC_SEL: trc_sel_reg <= I_WDATA[pam_pkg::EV_N-1:0];
					pam_pkg::REG_STACK_LO: stack_lo_reg <= I_WDATA[AW-1:0];
					pam_pkg::REG_STACK_HI: stack_hi_reg <= I_WDATA[AW-1:0];
					pam_pkg::REG_TRACK_BASE: track_base_reg <= I_WDATA[AW-1:0];
					default: ;
				endcase
			end
		end
	end

	// Block k sits at three words from REG_BLK_BASE + 4k: start, end, attribute.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				blk_start_reg[i] <= '0;
				blk_end_reg[i] <= '0;
				blk_attr_reg[i] <= 4'h0;
			end
			for (int i = 0; i < NUM_TASKS; i++) begin
				tsk_lo_reg[i] <= '1;
				tsk_hi_reg[i] <= '0;
			end
		end else if (I_WR) begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i)) begin
					blk_start_reg[i] <= I_WDATA[AW-1:0];
				end
				if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i + 1)) begin
					blk_end_reg[i] <= I_WDATA[AW-1:0];
				end
				if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i + 2)) begin
					blk_attr_reg[i] <= I_WDATA[3:0];
				end
			end
			for (int i = 0; i < NUM_TASKS; i++) begin
				if (I_ADDR == 8'(pam_pkg::REG_TSK_BASE + 2 * i)) begin
					tsk_lo_reg[i] <= I_WDATA[AW-1:0];
				end
				if (I_ADDR == 8'(pam_pkg::REG_TSK_BASE + 2 * i + 1)) begin
					tsk_hi_reg[i] <= I_WDATA[AW-1:0];
				end
			end
		end
	end

	// Read data; unmapped addresses read as zero.
	always_comb begin
		rdata_next = pam_pkg::REG_RST;
		unique case (I_ADDR)
			pam_pkg::REG_CTRL: rdata_next = 32'(ctrl_reg[1:0]);
			pam_pkg::REG_INTERVAL: rdata_next = 32'(interval_reg);
			pam_pkg::REG_STATUS: rdata_next = 32'(status_reg);
			pam_pkg::REG_MASK: rdata_next = 32'(mask_reg);
			pam_pkg::REG_BRK_SEL: rdata_next = 32'(brk_sel_reg);
			pam_pkg::REG_TRC_SEL: rdata_next = 32'(trc_sel_reg);
			pam_pkg::REG_STACK_LO: rdata_next = 32'(stack_lo_reg);
			pam_pkg::REG_STACK_HI: rdata_next = 32'(stack_hi_reg);
			pam_pkg::REG_PTIME_LO: rdata_next = time_reg[0][31:0];
			pam_pkg::REG_PTIME_HI: rdata_next = 32'(time_reg[0][TW-1:32]);
			pam_pkg::REG_PCOUNT: rdata_next = 32'(pass_reg);
			pam_pkg::REG_STIME_LO: rdata_next = time_reg[1][31:0];
			pam_pkg::REG_STIME_HI: rdata_next = 32'(time_reg[1][TW-1:32]);
			pam_pkg::REG_TRACK_BASE: rdata_next = 32'(track_base_reg);
			default: begin
				for (int i = 0; i < NUM_BLOCKS; i++) begin
					if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i)) rdata_next = 32'(blk_start_reg[i]);
					if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i + 1)) rdata_next = 32'(blk_end_reg[i]);
					if (I_ADDR == 8'(pam_pkg::REG_BLK_BASE + 4 * i + 2)) rdata_next = 32'(blk_attr_reg[i]);
				end
				for (int i = 0; i < NUM_TASKS; i++) begin
					if (I_ADDR == 8'(pam_pkg::REG_TSK_BASE + 2 * i)) rdata_next = 32'(tsk_lo_reg[i]);
					if (I_ADDR == 8'(pam_pkg::REG_TSK_BASE + 2 * i + 1)) rdata_next = 32'(tsk_hi_reg[i]);
				end
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RDATA <= pam_pkg::REG_RST;
		end else if (I_RD) begin
			O_RDATA <= rdata_next;
		end else begin
			O_RDATA <= pam_pkg::REG_RST;
		end
	end

endmodule : profile_access_monitor

//--- design/pam_pkg.sv
// Constants, register map and carrier types of the profile and access monitor.
// Assumes one monitor clock of 20 MHz shared with the observed bus interface.
package pam_pkg;

	// Clock and measurement timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int RES_UNIT_NS = 10;
	localparam int CLK_UNITS = CLK_PERIOD_NS / RES_UNIT_NS;
	localparam int RES_10NS_NS = 10;
	localparam int RES_20NS_NS = 20;
	localparam int RES_40NS_NS = 40;
	localparam int RES_80NS_NS = 80;
	localparam int RES_160NS_NS = 160;
	localparam int RES_1600NS_NS = 1600;

	// Counter and bus widths.
	localparam int TIME_W = 40;
	localparam int PASS_W = 16;
	localparam int ADDR_W = 24;
	localparam int TASK_W = 2;
	localparam int DATA_W = 32;
	localparam int REG_AW = 8;

	// Register word addresses.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INTERVAL = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_MASK = 8'h03;
	localparam logic [7:0] REG_BRK_SEL = 8'h04;
	localparam logic [7:0] REG_TRC_SEL = 8'h05;
	localparam logic [7:0] REG_STACK_LO = 8'h06;
	localparam logic [7:0] REG_STACK_HI = 8'h07;
	localparam logic [7:0] REG_PTIME_LO = 8'h08;
	localparam logic [7:0] REG_PTIME_HI = 8'h09;
	localparam logic [7:0] REG_PCOUNT = 8'h0A;
	localparam logic [7:0] REG_STIME_LO = 8'h0B;
	localparam logic [7:0] REG_STIME_HI = 8'h0C;
	localparam logic [7:0] REG_TRACK_BASE = 8'h0D;
	localparam logic [7:0] REG_BLK_BASE = 8'h10;
	localparam logic [7:0] REG_TSK_BASE = 8'h50;

	// Control register bits.
	localparam int CTRL_STACK_EN = 0;
	localparam int CTRL_UNINIT_EN = 1;
	localparam int CTRL_CLR_PROF = 2;
	localparam int CTRL_CLR_MAP = 3;

	// Block attribute register: bits 2:0 attribute, bit 3 block in use.
	localparam int BLK_EN_BIT = 3;

	// Event bit positions in status, mask and trigger selects.
	localparam int EV_PROT = 0;
	localparam int EV_UNINIT = 1;
	localparam int EV_STACK = 2;
	localparam int EV_PERF_OVF = 3;
	localparam int EV_PROF_OVF = 4;
	localparam int EV_TRACE_OVF = 5;
	localparam int EV_TASK_STACK = 6;
	localparam int EV_DISPATCH = 7;
	localparam int EV_N = 8;

	// Reset values.
	localparam logic [2:0] INTERVAL_RST = 3'h0;
	localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		INT_10NS = 3'b000,
		INT_20NS = 3'b001,
		INT_40NS = 3'b010,
		INT_80NS = 3'b011,
		INT_160NS = 3'b100,
		INT_1600NS = 3'b101
	} interval_t;

	typedef enum logic [2:0] {
		ATTR_RW = 3'b000,
		ATTR_RO = 3'b001,
		ATTR_WO = 3'b010,
		ATTR_DIS = 3'b011,
		ATTR_DIS_OS = 3'b100
	} attr_t;

	// One observed bus access of the target core.
	typedef struct packed {
		logic valid;
		logic write;
		logic os;
		logic [TASK_W-1:0] task_id;
		logic [ADDR_W-1:0] addr;
	} access_t;

endpackage : pam_pkg

//--- sim/profile_and_access_monitor_sva.sv
// Concurrent checks on the event and trigger outputs of the monitor.
// Assumes one clock domain and the asynchronous active-low reset of the design.
`timescale 1ns/1ps
module profile_and_access_monitor_sva (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	// Observed target.
	input wire pam_pkg::access_t I_ACC,
	input wire logic I_SP_VALID,
	input wire logic I_TASK_VALID,
	input wire logic I_PROF_ENTER,
	input wire logic I_PROF_ACTIVE,
	input wire logic I_SECT_ACTIVE,
	input wire logic I_TRACE_WR,
	input wire logic I_TRACE_FULL,
	// Events and triggers.
	input wire logic [pam_pkg::EV_N-1:0] O_EVENT,
	input wire logic O_BRK_TRIG,
	input wire logic O_TRC_TRIG
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RST_N);

	chk_prot_cause: assert property (
		O_EVENT[pam_pkg::EV_PROT] |-> $past(I_ACC.valid)) else $error("prot event without access");
	chk_uninit_read: assert property (
		O_EVENT[pam_pkg::EV_UNINIT] |-> $past(I_ACC.valid && !I_ACC.write))
		else $error("uninit event without read");
	chk_stack_sample: assert property (
		O_EVENT[pam_pkg::EV_STACK] |-> $past(I_SP_VALID)) else $error("stack event without sample");
	chk_perf_section: assert property (
		O_EVENT[pam_pkg::EV_PERF_OVF] |-> $past(I_SECT_ACTIVE)) else $error("perf event idle");
	chk_prof_cause: assert property (
		O_EVENT[pam_pkg::EV_PROF_OVF] |-> $past(I_PROF_ENTER || I_PROF_ACTIVE))
		else $error("profile overflow without activity");
	chk_trace_set: assert property (
		I_TRACE_WR && I_TRACE_FULL |=> O_EVENT[pam_pkg::EV_TRACE_OVF]) else $error("trace ovf missed");
	chk_trace_only: assert property (
		!(I_TRACE_WR && I_TRACE_FULL) |=> !O_EVENT[pam_pkg::EV_TRACE_OVF])
		else $error("trace ovf without cause");
	chk_task_write: assert property (
		O_EVENT[pam_pkg::EV_TASK_STACK] |-> $past(I_ACC.valid && I_ACC.write))
		else $error("task stack event without write");
	chk_dispatch_valid: assert property (
		O_EVENT[pam_pkg::EV_DISPATCH] |-> $past(I_TASK_VALID)) else $error("dispatch without task");
	chk_brk_source: assert property (
		O_BRK_TRIG |-> |O_EVENT) else $error("break trigger without event");
	chk_trc_source: assert property (
		O_TRC_TRIG |-> |O_EVENT) else $error("trace trigger without event");
endmodule : profile_and_access_monitor_sva

bind profile_access_monitor profile_and_access_monitor_sva chk (.I_MCLK(I_MCLK),
	.I_RST_N(I_RST_N), .I_ACC(I_ACC), .I_SP_VALID(I_SP_VALID), .I_TASK_VALID(I_TASK_VALID),
	.I_PROF_ENTER(I_PROF_ENTER), .I_PROF_ACTIVE(I_PROF_ACTIVE), .I_SECT_ACTIVE(I_SECT_ACTIVE),
	.I_TRACE_WR(I_TRACE_WR), .I_TRACE_FULL(I_TRACE_FULL), .O_EVENT(O_EVENT),
	.O_BRK_TRIG(O_BRK_TRIG), .O_TRC_TRIG(O_TRC_TRIG));

//--- sim/target_core_model.sv
// Behavioural model of the observed target core and its trace store.
// Assumes the bench calls its tasks; all drives except those of idle follow a rising clock edge.
`timescale 1ns/1ps
module target_core_model (
	// Clock.
	input wire logic i_clk,
	// Observed target signals.
	output pam_pkg::access_t o_acc,
	output logic [23:0] o_sp,
	output logic o_sp_valid,
	output logic [1:0] o_task_id,
	output logic o_task_valid,
	output logic o_prof_enter,
	output logic o_prof_active,
	output logic o_sect_active,
	output logic o_trace_wr,
	output logic o_trace_full
);
	// Idle fields are random where no event can follow; the stack pointer stays inside the limits.
	task automatic idle();
		o_acc <= {1'h0, 28'($urandom)};
		o_sp <= 24'h1000 + 24'($urandom % 4096);
		o_sp_valid <= 1'($urandom);
		o_task_id <= 2'($urandom);
		o_task_valid <= 1'h0;
		o_prof_enter <= 1'h0;
		o_prof_active <= 1'h0;
		o_sect_active <= 1'h0;
		o_trace_wr <= 1'h0;
		o_trace_full <= 1'($urandom);
	endtask : idle

	// Released fields take the inverse, so a stale value can never pass for a live one.
	task automatic access(input logic w, input logic os, input logic [1:0] t,
		input logic [23:0] a);
		pam_pkg::access_t x;
		x = {1'h1, w, os, t, a};
		@(posedge i_clk);
		o_acc <= x;
		@(posedge i_clk);
		o_acc <= ~x;
	endtask : access

	task automatic stack(input logic [23:0] s);
		@(posedge i_clk);
		o_sp <= s;
		o_sp_valid <= 1'h1;
		@(posedge i_clk);
		o_sp <= ~s;
		o_sp_valid <= 1'h0;
	endtask : stack

	task automatic task_sw(input logic [1:0] id);
		@(posedge i_clk);
		o_task_id <= id;
		o_task_valid <= 1'h1;
		@(posedge i_clk);
		o_task_id <= ~id;
		o_task_valid <= 1'h0;
	endtask : task_sw

	task automatic trace(input logic full);
		@(posedge i_clk);
		o_trace_wr <= 1'h1;
		o_trace_full <= full;
		@(posedge i_clk);
		o_trace_wr <= 1'h0;
		o_trace_full <= 1'h0;
	endtask : trace

	task automatic run(input int n);
		@(posedge i_clk);
		o_prof_active <= 1'h1;
		o_sect_active <= 1'h1;
		repeat (n) @(posedge i_clk);
		o_prof_active <= 1'h0;
		o_sect_active <= 1'h0;
	endtask : run

	task automatic enter(input int n);
		@(posedge i_clk);
		o_prof_enter <= 1'h1;
		repeat (n) @(posedge i_clk);
		o_prof_enter <= 1'h0;
	endtask : enter
endmodule : target_core_model

//--- sim/profile_and_access_monitor_tb.sv
// Self-checking bench for the profile and access monitor.
// Assumes the target core model and the bound checker.
`timescale 1ns/1ps
module profile_and_access_monitor_tb;
	logic I_MCLK = 1'h0;
	logic I_RST_N = 1'h0;
	logic I_WR = 1'h0;
	logic I_RD = 1'h0;
	logic rd_seen = 1'h0;
	logic [7:0] I_ADDR = 8'h0;
	logic [31:0] I_WDATA = 32'h0;
	logic [31:0] O_RDATA;
	logic [7:0] O_EVENT;
	logic O_IRQ, O_BRK_TRIG, O_TRC_TRIG, sp_v, tk_v, pe, pa, sa, tw, tf;
	logic [23:0] sp;
	logic [1:0] tk;
	logic [7:0] b;
	pam_pkg::access_t acc;
	logic [31:0] exp_q[$];
	logic [31:0] seen_q[$];
	int error_cnt = 0;
	int total_checks = 0;
	int res[6] = '{10, 20, 40, 80, 160, 1600};

	initial begin
		forever #25 I_MCLK = ~I_MCLK;
	end

	profile_access_monitor uut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_ACC(acc), .I_SP(sp),
		.I_SP_VALID(sp_v), .I_TASK_ID(tk), .I_TASK_VALID(tk_v), .I_PROF_ENTER(pe),
		.I_PROF_ACTIVE(pa), .I_SECT_ACTIVE(sa), .I_TRACE_WR(tw), .I_TRACE_FULL(tf),
		.O_IRQ(O_IRQ), .O_EVENT(O_EVENT), .O_BRK_TRIG(O_BRK_TRIG), .O_TRC_TRIG(O_TRC_TRIG));

	target_core_model core (.i_clk(I_MCLK), .o_acc(acc), .o_sp(sp), .o_sp_valid(sp_v),
		.o_task_id(tk), .o_task_valid(tk_v), .o_prof_enter(pe), .o_prof_active(pa),
		.o_sect_active(sa), .o_trace_wr(tw), .o_trace_full(tf));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// Read data stands only in the cycle after the strobe, so it is taken at that edge.
	always @(posedge I_MCLK) begin
		if (rd_seen) begin
			chk(O_RDATA, exp_q.pop_front());
		end
		if (I_RST_N && (O_EVENT !== 8'h00 || O_BRK_TRIG !== 1'h0 || O_TRC_TRIG !== 1'h0)) begin
			seen_q.push_back({22'h0, O_TRC_TRIG, O_BRK_TRIG, O_EVENT});
		end
		rd_seen <= I_RD;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_MCLK);
		I_WR <= 1'h1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_MCLK);
		I_WR <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge I_MCLK);
		I_RD <= 1'h1;
		I_ADDR <= a;
		exp_q.push_back(e);
		@(posedge I_MCLK);
		I_RD <= 1'h0;
	endtask : rd

	// Status is sticky, so it is cleared after each look to keep checks independent.
	// Each nonzero status expects exactly one event pulse with its trigger bits.
	task automatic evchk(input logic [31:0] e);
		rd(pam_pkg::REG_STATUS, e);
		wr(pam_pkg::REG_STATUS, 32'hFF);
		chk(32'(seen_q.size()), 32'(e != 32'h0));
		if (seen_q.size() > 0) begin
			chk(seen_q.pop_front(), {22'h0, |(e[7:0] & 8'h0F), e != 32'h0, e[7:0]});
		end
		seen_q.delete();
	endtask : evchk

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		#(90000 * 50);
		error_cnt++;
		conclude();
	end

	initial begin
		void'($urandom(3504));
		core.idle();
		repeat (3) @(posedge I_MCLK);
		I_RST_N <= 1'h1;
		rd(pam_pkg::REG_INTERVAL, 32'h0);
		rd(pam_pkg::REG_STACK_HI, 32'hFFFFFF);
		rd(8'hFF, 32'h0);
		wr(pam_pkg::REG_BRK_SEL, 32'hFF);
		wr(pam_pkg::REG_TRC_SEL, 32'h0F);
		core.access(1'h1, 1'h0, 2'h0, 24'($urandom));
		core.access(1'h0, 1'h0, 2'h0, 24'($urandom));
		evchk(32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			b = pam_pkg::REG_BLK_BASE + 8'(20 * i);
			wr(b, 32'h100);
			wr(b + 8'h1, 32'h1FF);
			wr(b + 8'h2, 32'(i + 9));
			core.access(1'h1, 1'h0, 2'h0, 24'h100 + 24'($urandom % 256));
			evchk(32'(4'hD >> i & 1));
			core.access(1'h0, 1'h0, 2'h0, 24'h100 + 24'($urandom % 256));
			evchk(32'(4'hE >> i & 1));
			core.access(1'h1, 1'h1, 2'h0, 24'h1FF);
			evchk(32'(4'h5 >> i & 1));
			core.access(1'h0, 1'h0, 2'h0, 24'h200);
			evchk(32'h0);
			wr(b + 8'h2, 32'h0);
		end
		wr(pam_pkg::REG_MASK, 32'h1);
		wr(pam_pkg::REG_BLK_BASE + 8'h2, 32'h9);
		core.access(1'h1, 1'h0, 2'h0, 24'h180);
		#1 chk(32'(O_IRQ), 32'h1);
		wr(pam_pkg::REG_STATUS, 32'h1);
		#1 chk(32'(O_IRQ), 32'h0);
		chk(seen_q.pop_front(), 32'h301);
		wr(pam_pkg::REG_MASK, 32'h0);
		core.access(1'h1, 1'h0, 2'h0, 24'h180);
		#1 chk(32'(O_IRQ), 32'h0);
		evchk(32'h1);
		wr(pam_pkg::REG_BLK_BASE + 8'h2, 32'h0);
		$display("test protection done");
		wr(pam_pkg::REG_TRACK_BASE, 32'h200);
		wr(pam_pkg::REG_CTRL, 32'h3);
		core.access(1'h0, 1'h0, 2'h0, 24'h205);
		evchk(32'h2);
		core.access(1'h1, 1'h0, 2'h0, 24'h206);
		core.access(1'h0, 1'h0, 2'h0, 24'h206);
		evchk(32'h0);
		wr(pam_pkg::REG_STACK_LO, 32'h1000);
		wr(pam_pkg::REG_STACK_HI, 32'h1FFF);
		core.stack(24'h0FFF);
		evchk(32'h4);
		core.stack(24'h1000 + 24'($urandom % 4096));
		evchk(32'h0);
		core.stack(24'h2000);
		evchk(32'h4);
		wr(pam_pkg::REG_TSK_BASE + 8'h2, 32'h3000);
		wr(pam_pkg::REG_TSK_BASE + 8'h3, 32'h30FF);
		core.access(1'h1, 1'h0, 2'h0, 24'h3010);
		evchk(32'h40);
		core.access(1'h1, 1'h0, 2'h1, 24'h3010);
		evchk(32'h0);
		core.task_sw(2'h2);
		evchk(32'h80);
		core.task_sw(2'h2);
		evchk(32'h0);
		core.trace(1'h1);
		evchk(32'h20);
		core.trace(1'h0);
		evchk(32'h0);
		$display("test events done");
		for (int c = 0; c < 6; c++) begin
			wr(pam_pkg::REG_INTERVAL, 32'(c));
			wr(pam_pkg::REG_CTRL, 32'h4);
			core.run(160);
			rd(pam_pkg::REG_PTIME_LO, 32'(8000 / res[c]));
			rd(pam_pkg::REG_PTIME_HI, 32'h0);
			rd(pam_pkg::REG_STIME_LO, 32'(8000 / res[c]));
		end
		wr(pam_pkg::REG_INTERVAL, 32'h5);
		rd(pam_pkg::REG_PTIME_LO, 32'h5);
		wr(pam_pkg::REG_INTERVAL, 32'h0);
		rd(pam_pkg::REG_PTIME_LO, 32'h0);
		rd(pam_pkg::REG_STIME_LO, 32'h0);
		$display("test timers done");
		core.enter(3);
		rd(pam_pkg::REG_PCOUNT, 32'h3);
		core.enter(65532);
		rd(pam_pkg::REG_PCOUNT, 32'hFFFF);
		evchk(32'h0);
		core.enter(1);
		evchk(32'h10);
		rd(pam_pkg::REG_PCOUNT, 32'hFFFF);
		$display("test passes done");
		chk(32'(seen_q.size()), 32'h0);
		repeat (3) @(posedge I_MCLK);
		conclude();
	end
endmodule : profile_and_access_monitor_tb
